// file: verilog/phy_evt_pkg.sv
package phy_evt_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_STATE  = 8'h10;
    // paged window: indexes 8 to 15, byte address is four times the index
    localparam logic [5:0] WIN_FIRST_IDX = 6'h08;
    localparam logic [5:0] WIN_LAST_IDX  = 6'h0F;
    localparam logic [5:0] WIN_PORT0_IDX = 6'h08;
    localparam logic [5:0] WIN_PORT1_IDX = 6'h09;
    localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;
    localparam logic [3:0] PORT_COUNT       = 4'h1;

    // control register fields
    localparam int CTL_SRR     = 0;
    localparam int CTL_ACCEL   = 1;
    localparam int CTL_MULTI   = 2;
    localparam int CTL_RESUME  = 3;
    localparam int CTL_PINT    = 4;
    localparam int CTL_BIASDIS = 5;
    localparam int CTL_PAGE_LO = 8;
    localparam int CTL_PORT_LO = 12;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hF73F;

    // event bits, shared by status, clear and enable
    localparam int EV_LOOP = 0;
    localparam int EV_PWR  = 1;
    localparam int EV_TMO  = 2;
    localparam int EV_PORT = 3;
    localparam int EV_W    = 4;
    localparam logic [3:0] EV_RESET = 4'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // bus reset durations
    localparam int CLK_MHZ         = 200;
    localparam int SHORT_RESET_NS  = 1300;
    localparam int LONG_RESET_US   = 166;
    localparam int SHORT_RESET_CYC = (SHORT_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int LONG_RESET_CYC  = LONG_RESET_US * CLK_MHZ;

    typedef struct packed {
        logic [1:0] astat;
        logic [1:0] bstat;
        logic       child;
        logic       connected;
        logic       bias;
        logic       disabled;
        logic [2:0] peer_speed;
        logic       fault;
    } port_status_s;
endpackage : phy_evt_pkg

// file: verilog/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule : sync2

// file: verilog/bus_reset_seq.sv
`timescale 1ns/1ps
module bus_reset_seq #(
    parameter int SHORT_CYC = phy_evt_pkg::SHORT_RESET_CYC,
    parameter int LONG_CYC  = phy_evt_pkg::LONG_RESET_CYC
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic start,
    input  wire logic long_sel,
    output logic      active,
    output logic      long_o,
    output logic      done
);
    // the counter must hold whichever form is longer; a short long-reset setting must not wrap it
    localparam int CW  = $clog2(((LONG_CYC > SHORT_CYC) ? LONG_CYC : SHORT_CYC) + 1);
    localparam int SC1 = SHORT_CYC + 1;
    typedef enum {SEQ_IDLE, SEQ_RUN} seq_state_e;

    seq_state_e    state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          long_r, long_nxt;
    logic          done_r, done_nxt;
    logic          active_r, active_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        long_nxt  = long_r;
        done_nxt  = 1'b0;
        unique case (state_r)
            SEQ_IDLE: if (start) begin
                state_nxt = SEQ_RUN;
                long_nxt  = long_sel;
                cnt_nxt   = long_sel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
            end
            SEQ_RUN: if (cnt_r == '0) begin
                state_nxt = SEQ_IDLE;
                done_nxt  = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 1'b1;
            end
        endcase
        active_nxt = (state_nxt == SEQ_RUN);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r  <= SEQ_IDLE;
            cnt_r    <= '0;
            long_r   <= 1'b0;
            done_r   <= 1'b0;
            active_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            long_r   <= long_nxt;
            done_r   <= done_nxt;
            active_r <= active_nxt;
        end
    end

    assign active = active_r;
    assign long_o = long_r;
    assign done   = done_r;

    chk_short_span: assert property (@(posedge aclk) disable iff (!aresetn)
        start && !active_r && !long_sel |-> ##SC1 done_r)
        else $error("short bus reset length wrong");
endmodule : bus_reset_seq

// file: verilog/phy_base_event_regs.sv
// Behaviour
// - setting the short-reset request starts a 1.3 us arbitrated reset when bus allows
// - the short-reset request drops to zero whenever any bus reset takes place; here a request written in that same cycle stays set
// - a legacy node on the bus turns a short reset request into a long reset
// - arbitration timeout at tree identification start sets the loop flag
// - loop, power-fail, timeout and port-event flags clear on reset or written one
// - loop flag with resume-alert enable wakes an inactive link layer
// - in-loop nodes flag loop; others flag state timeout and reset the bus
// - each falling edge of cable power sense sets the power-fail flag
// - a state timeout sets the timeout flag and starts a bus reset
// - with port interrupts on, port status changes set the port-event flag
// - with resume-alert on, start of resume sets the port-event flag
// - accelerated arbitration enable resets to zero, survives bus reset
// - multispeed concatenation enable resets to zero, survives bus reset
// - 3-bit page selector steers window 8 to 15, resets to zero, survives bus reset
// - 4-bit port selector picks the port, resets to zero, survives bus reset
// - an unsupported port number makes the whole port status page read zero
// - resume-alert enable resets to zero and survives bus reset
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module phy_base_event_regs #(
    parameter int AW             = 8,
    parameter int LONG_RESET_CYC = phy_evt_pkg::LONG_RESET_CYC
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [AW-1:0]             s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [AW-1:0]             s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      cable_power_sense_input,
    input  wire logic                      arb_timeout,
    input  wire logic                      ident_timeout,
    input  wire logic                      resume_start,
    input  wire logic                      link_active,
    input  wire logic                      legacy_present,
    input  wire logic                      bus_idle,
    input  wire logic                      bus_reset_in,
    input  wire phy_evt_pkg::port_status_s port_status,
    output logic                           irq,
    output logic                           link_wake,
    output logic                           bus_reset_active,
    output logic                           bus_reset_long,
    output logic                           accel_en,
    output logic                           multi_en,
    output logic [2:0]                     page_sel,
    output logic [3:0]                     port_sel
);
    localparam int EW = phy_evt_pkg::EV_W;

    function automatic logic [5:0] idx_of(input logic [AW-1:0] a);
        return a[7:2];
    endfunction : idx_of

    function automatic logic mapped(input logic [5:0] i);
        return i == idx_of(phy_evt_pkg::OFS_CTRL) || i == idx_of(phy_evt_pkg::OFS_STATUS)
            || i == idx_of(phy_evt_pkg::OFS_CLEAR) || i == idx_of(phy_evt_pkg::OFS_ENABLE)
            || i == idx_of(phy_evt_pkg::OFS_STATE)
            || (i >= phy_evt_pkg::WIN_FIRST_IDX && i <= phy_evt_pkg::WIN_LAST_IDX);
    endfunction : mapped

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
        logic [15:0] m;
        m = old;
        if (st[0]) m[7:0] = wd[7:0];
        if (st[1]) m[15:8] = wd[15:8];
        return (m & phy_evt_pkg::CTRL_WMASK) | (old & ~phy_evt_pkg::CTRL_WMASK);
    endfunction : merge16

    // ---------------- AXI4-Lite slave ----------------
    logic          aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [AW-1:0] awaddr_r, awaddr_nxt;
    logic [31:0]   wdata_r, wdata_nxt;
    logic [3:0]    wstrb_r, wstrb_nxt;
    logic          awready_r, awready_nxt, wready_r, wready_nxt;
    logic          bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]    bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]   rdata_r, rdata_nxt, rd_word;
    logic          wr_fire;
    logic [5:0]    wr_idx, rd_idx;

    // one write in flight: both halves wait here until the response is taken
    assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_idx  = idx_of(awaddr_r);
    assign rd_idx  = idx_of(s_axi_araddr);

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        awaddr_nxt  = awaddr_r;
        w_hold_nxt  = w_hold_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && awready_r) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_hold_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
        if (wr_fire) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = mapped(wr_idx) ? phy_evt_pkg::RESP_OKAY : phy_evt_pkg::RESP_SLVERR;
        end
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt  = !w_hold_nxt && !bvalid_nxt;
        arready_nxt = arready_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_word;
            rresp_nxt  = mapped(rd_idx) ? phy_evt_pkg::RESP_OKAY : phy_evt_pkg::RESP_SLVERR;
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r  <= '0;
            w_hold_r  <= 1'b0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= phy_evt_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= phy_evt_pkg::RESP_OKAY;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            awaddr_r  <= awaddr_nxt;
            w_hold_r  <= w_hold_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    // ---------------- bus reset control ----------------
    logic cps_s, seq_active, seq_long, seq_start, seq_long_sel, reset_taken;

    sync2 #(.W(1)) u_cps_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (cable_power_sense_input),
        .q       (cps_s)
    );

    logic [15:0] ctrl_r, ctrl_nxt;
    logic [EW-1:0] status_r, status_nxt, en_r, en_nxt, ev_set, ev_clr;

    // state timeouts reset right away; a short request waits for an idle bus
    assign seq_start    = !seq_active && (ident_timeout
                       || (ctrl_r[phy_evt_pkg::CTL_SRR] && bus_idle));
    // old nodes cannot do short resets, so fall back to the long form
    assign seq_long_sel = ident_timeout || legacy_present;
    assign reset_taken  = seq_start || bus_reset_in;

    bus_reset_seq #(
        .SHORT_CYC (phy_evt_pkg::SHORT_RESET_CYC),
        .LONG_CYC  (LONG_RESET_CYC)
    ) u_seq (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (seq_start),
        .long_sel (seq_long_sel),
        .active   (seq_active),
        .long_o   (seq_long),
        .done     ()
    );

    // ---------------- control, events, interrupt ----------------
    phy_evt_pkg::port_status_s prev_r, prev_nxt;
    logic prev_ok_r, prev_ok_nxt, cps_d_r, cps_d_nxt, wake_r, wake_nxt, irq_r, irq_nxt;
    logic wr_ctrl, srr_wset, port_chg, cps_fall;

    assign wr_ctrl  = wr_fire && wr_idx == idx_of(phy_evt_pkg::OFS_CTRL);
    assign srr_wset = wr_ctrl && wstrb_r[0] && wdata_r[phy_evt_pkg::CTL_SRR];
    assign cps_fall = cps_d_r && !cps_s;
    assign port_chg = prev_ok_r && (port_status.connected != prev_r.connected
                   || port_status.disabled != prev_r.disabled
                   || port_status.fault != prev_r.fault
                   || (!ctrl_r[phy_evt_pkg::CTL_BIASDIS] && port_status.bias != prev_r.bias));

    always_comb begin
        ctrl_nxt = ctrl_r;
        en_nxt   = en_r;
        ev_clr   = '0;
        if (wr_ctrl) ctrl_nxt = merge16(ctrl_r, wdata_r, wstrb_r);
        // a fresh request written in the same cycle outlives the reset it meets
        if (reset_taken && !srr_wset) ctrl_nxt[phy_evt_pkg::CTL_SRR] = 1'b0;
        if (wr_fire && wr_idx == idx_of(phy_evt_pkg::OFS_ENABLE) && wstrb_r[0])
            en_nxt = wdata_r[EW-1:0];
        if (wr_fire && wr_idx == idx_of(phy_evt_pkg::OFS_CLEAR) && wstrb_r[0])
            ev_clr = wdata_r[EW-1:0];
        ev_set = '0;
        // arbitration timeout only reaches nodes inside a loop; others see ident timeout
        ev_set[phy_evt_pkg::EV_LOOP] = arb_timeout;
        ev_set[phy_evt_pkg::EV_PWR]  = cps_fall;
        ev_set[phy_evt_pkg::EV_TMO]  = ident_timeout;
        ev_set[phy_evt_pkg::EV_PORT] = (ctrl_r[phy_evt_pkg::CTL_PINT] && port_chg)
                                    || (ctrl_r[phy_evt_pkg::CTL_RESUME] && resume_start);
        // set beats clear so no event is lost
        status_nxt  = (status_r & ~ev_clr) | ev_set;
        prev_nxt    = port_status;
        prev_ok_nxt = 1'b1;
        cps_d_nxt   = cps_s;
        wake_nxt    = status_r[phy_evt_pkg::EV_LOOP] && ctrl_r[phy_evt_pkg::CTL_RESUME]
                   && !link_active;
        irq_nxt     = |(status_r & en_r);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r    <= phy_evt_pkg::CTRL_RESET;
            en_r      <= phy_evt_pkg::EV_RESET;
            status_r  <= phy_evt_pkg::EV_RESET;
            prev_r    <= '0;
            prev_ok_r <= 1'b0;
            cps_d_r   <= 1'b0;
            wake_r    <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            en_r      <= en_nxt;
            status_r  <= status_nxt;
            prev_r    <= prev_nxt;
            prev_ok_r <= prev_ok_nxt;
            cps_d_r   <= cps_d_nxt;
            wake_r    <= wake_nxt;
            irq_r     <= irq_nxt;
        end
    end

    // ---------------- read mux ----------------
    logic port_ok;
    assign port_ok = ctrl_r[phy_evt_pkg::CTL_PORT_LO +: 4] < phy_evt_pkg::PORT_COUNT;

    always_comb begin
        rd_word = '0;
        if (rd_idx == idx_of(phy_evt_pkg::OFS_CTRL)) rd_word[15:0] = ctrl_r;
        else if (rd_idx == idx_of(phy_evt_pkg::OFS_STATUS)) rd_word[EW-1:0] = status_r;
        else if (rd_idx == idx_of(phy_evt_pkg::OFS_ENABLE)) rd_word[EW-1:0] = en_r;
        else if (rd_idx == idx_of(phy_evt_pkg::OFS_STATE))
            rd_word[3:0] = {wake_r, seq_long, seq_active, cps_s};
        // the window shows port page data only for an existing port on page zero
        else if (ctrl_r[phy_evt_pkg::CTL_PAGE_LO +: 3] == phy_evt_pkg::PAGE_PORT_STATUS
                 && port_ok) begin
            if (rd_idx == phy_evt_pkg::WIN_PORT0_IDX)
                rd_word[7:0] = {port_status.astat, port_status.bstat, port_status.child,
                                port_status.connected, port_status.bias, port_status.disabled};
            else if (rd_idx == phy_evt_pkg::WIN_PORT1_IDX)
                rd_word[7:0] = {port_status.peer_speed, ctrl_r[phy_evt_pkg::CTL_PINT],
                                port_status.fault, 3'h0};
        end
    end

    assign s_axi_awready    = awready_r;
    assign s_axi_wready     = wready_r;
    assign s_axi_bresp      = bresp_r;
    assign s_axi_bvalid     = bvalid_r;
    assign s_axi_arready    = arready_r;
    assign s_axi_rdata      = rdata_r;
    assign s_axi_rresp      = rresp_r;
    assign s_axi_rvalid     = rvalid_r;
    assign irq              = irq_r;
    assign link_wake        = wake_r;
    assign bus_reset_active = seq_active;
    assign bus_reset_long   = seq_long;
    assign accel_en         = ctrl_r[phy_evt_pkg::CTL_ACCEL];
    assign multi_en         = ctrl_r[phy_evt_pkg::CTL_MULTI];
    assign page_sel         = ctrl_r[phy_evt_pkg::CTL_PAGE_LO +: 3];
    assign port_sel         = ctrl_r[phy_evt_pkg::CTL_PORT_LO +: 4];

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_srr_drop: assert property (reset_taken && !srr_wset |=>
        !ctrl_r[phy_evt_pkg::CTL_SRR]) else $error("short reset request not dropped");
    chk_legacy_long: assert property (seq_start && legacy_present |=>
        seq_active && seq_long) else $error("legacy bus did not get long reset");
    chk_short_go: assert property (ctrl_r[phy_evt_pkg::CTL_SRR] && bus_idle && !seq_active
        && !legacy_present && !ident_timeout |=> seq_active && !seq_long)
        else $error("short reset did not start");
    chk_loop_set: assert property (arb_timeout |=> status_r[phy_evt_pkg::EV_LOOP])
        else $error("loop flag not set");
    chk_flag_clear: assert property (wr_fire && wr_idx == idx_of(phy_evt_pkg::OFS_CLEAR)
        && wstrb_r[0] && wdata_r[phy_evt_pkg::EV_PWR] && !cps_fall
        |=> !status_r[phy_evt_pkg::EV_PWR]) else $error("power flag not cleared");
    chk_zero_keep: assert property (status_r[phy_evt_pkg::EV_LOOP] && !ev_clr[phy_evt_pkg::EV_LOOP]
        |=> status_r[phy_evt_pkg::EV_LOOP]) else $error("loop flag lost");
    chk_link_wake: assert property (status_r[phy_evt_pkg::EV_LOOP]
        && ctrl_r[phy_evt_pkg::CTL_RESUME] && !link_active |=> link_wake)
        else $error("link not woken");
    chk_pwr_fall: assert property ($fell(cps_s) |=> status_r[phy_evt_pkg::EV_PWR])
        else $error("power fail not flagged");
    chk_tmo_reset: assert property (ident_timeout && !seq_active
        |=> status_r[phy_evt_pkg::EV_TMO] && seq_active) else $error("timeout not handled");
    chk_port_evt: assert property ((ctrl_r[phy_evt_pkg::CTL_RESUME] && resume_start)
        or (ctrl_r[phy_evt_pkg::CTL_PINT] && prev_ok_r && $changed(port_status.fault))
        |=> status_r[phy_evt_pkg::EV_PORT]) else $error("port event missed");
    chk_ctrl_keep: assert property (bus_reset_in && !wr_ctrl |=>
        $stable(ctrl_r[15:1])) else $error("control changed on bus reset");
    chk_port_zero: assert property (s_axi_arvalid && arready_r && !port_ok
        && rd_idx >= phy_evt_pkg::WIN_FIRST_IDX |=> s_axi_rdata == 32'h0)
        else $error("bad port window not zero");

    cov_short_reset: cover property (seq_start && !seq_long_sel);
    cov_long_reset: cover property (seq_start && legacy_present);
    cov_irq: cover property ($rose(irq_r));
    cov_set_clear: cover property (ev_set[phy_evt_pkg::EV_LOOP] && ev_clr[phy_evt_pkg::EV_LOOP]);
endmodule : phy_base_event_regs

// file: sim/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
    input  wire logic       aclk,
    input  wire logic [4:0] fire,
    output logic            arb_timeout,
    output logic            ident_timeout,
    output logic            resume_start,
    output logic            bus_reset_in,
    output logic            cable_power_sense_input
);
    // pulses leave one edge late; cable power idles high from the first edge, inside reset
    always @(posedge aclk) begin
        {cable_power_sense_input, bus_reset_in, resume_start, ident_timeout, arb_timeout} <= fire ^ 5'h10;
    end
endmodule : far_side_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] CT = phy_evt_pkg::OFS_CTRL;
    localparam logic [7:0] ST = phy_evt_pkg::OFS_STATUS;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, link_wake;
    logic bus_reset_active, bus_reset_long, accel_en, multi_en, link_active, legacy_present;
    logic cable_power_sense_input, arb_timeout, ident_timeout, resume_start, bus_reset_in, bus_idle;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0] page_sel;
    logic [3:0] port_sel, s_axi_wstrb;
    logic [4:0] fire;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, ctrl, rd_d;
    phy_evt_pkg::port_status_s port_status;
    int error_cnt = 0, compares = 0, act_len = 0, run = 0, seed;
    always #2.5 aclk = ~aclk;
    phy_base_event_regs #(.LONG_RESET_CYC(40)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cable_power_sense_input,
        .arb_timeout, .ident_timeout, .resume_start, .link_active, .legacy_present, .bus_idle,
        .bus_reset_in, .port_status, .irq, .link_wake, .bus_reset_active, .bus_reset_long,
        .accel_en, .multi_en, .page_sel, .port_sel);
    far_side_model u_far (.aclk, .fire, .arb_timeout, .ident_timeout, .resume_start,
        .bus_reset_in, .cable_power_sense_input);
    // length of the last bus reset, so a reset that starts before the write answer is not missed
    always @(posedge aclk) begin
        run <= bus_reset_active ? run + 1 : 0;
        if (!bus_reset_active && run != 0) act_len <= run;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 99);
        {rd_d, rsp} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (n == 99) begin
            error_cnt++;
            close_out();
        end
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_d, exp);
    endtask : rdchk
    task automatic pulse(input logic [4:0] f);
        @(posedge aclk);
        fire <= f;
        @(posedge aclk);
        fire <= 5'h0;
        repeat (4) @(posedge aclk);
    endtask : pulse
    task automatic wait_rst(input int len, input logic lng);
        for (int n = 0; n < 600 && act_len == 0; n++) @(posedge aclk);
        chk(act_len, len);
        chk(bus_reset_long, lng);
        if (act_len == 0) close_out();
        act_len = 0;
    endtask : wait_rst
    initial begin
        seed = 32'h7E5A;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire, legacy_present} = '0;
        {s_axi_wstrb, link_active, bus_idle} = 6'h3F;
        port_status = 12'($random(seed));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(CT, 32'h0);
        rdchk(ST, 32'h0);
        // short request kept clear here; port nonzero, port and resume events on, bias masked
        ctrl = $random(seed) & 32'hF73E | 32'h1038;
        bus(1'b1, CT, ctrl);
        chk(rsp, phy_evt_pkg::RESP_OKAY);
        pulse(5'h08);
        rdchk(CT, ctrl);
        chk({accel_en, multi_en, page_sel, port_sel}, {ctrl[1], ctrl[2], ctrl[10:8], ctrl[15:12]});
        rdchk(8'h20, 32'h0);
        ctrl = ctrl & 32'h00FF;
        bus(1'b1, CT, ctrl);
        rdchk(8'h20, 32'(port_status[11:4]));
        rdchk(8'h24, {port_status[3:1], 1'b1, port_status[0], 3'h0});
        bus(1'b1, phy_evt_pkg::OFS_ENABLE, 32'h9);
        pulse(5'h01);
        pulse(5'h10);
        port_status.bias <= ~port_status.bias;
        pulse(5'h00);
        rdchk(ST, 32'h3);
        chk(irq, 1'b1);
        port_status.fault <= ~port_status.fault;
        pulse(5'h00);
        rdchk(ST, 32'hB);
        bus(1'b1, phy_evt_pkg::OFS_CLEAR, 32'h0);
        rdchk(ST, 32'hB);
        bus(1'b1, phy_evt_pkg::OFS_CLEAR, 32'hF);
        rdchk(ST, 32'h0);
        chk(irq, 1'b0);
        link_active <= 1'b0;
        pulse(5'h04);
        rdchk(ST, 32'h8);
        chk(link_wake, 1'b0);
        pulse(5'h01);
        chk(link_wake, 1'b1);
        link_active <= 1'b1;
        bus(1'b1, phy_evt_pkg::OFS_CLEAR, 32'hF);
        act_len = 0;
        pulse(5'h02);
        wait_rst(40, 1'b1);
        rdchk(ST, 32'h4);
        bus(1'b1, CT, ctrl | 32'h1);
        wait_rst(phy_evt_pkg::SHORT_RESET_NS * phy_evt_pkg::CLK_MHZ / 1000, 1'b0);
        rdchk(CT, ctrl);
        legacy_present <= 1'b1;
        bus(1'b1, CT, ctrl | 32'h1);
        wait_rst(40, 1'b1);
        rdchk(8'h14, 32'h0);
        chk(rsp, phy_evt_pkg::RESP_SLVERR);
        close_out();
    end
endmodule : tb_top
